// File: verilog/bisc_pkg.sv
package bisc_pkg;

	// ------------------------------------------------------------
	// command and reply codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_DEV_INQ    = 8'h20;
	localparam logic [7:0] CMD_CLK_INQ    = 8'h21;
	localparam logic [7:0] CMD_RATIO_INQ  = 8'h22;
	localparam logic [7:0] CMD_FREQ_INQ   = 8'h23;
	localparam logic [7:0] CMD_UBOOT_INQ  = 8'h24;
	localparam logic [7:0] CMD_USER_INQ   = 8'h25;
	localparam logic [7:0] CMD_BLOCK_INQ  = 8'h26;
	localparam logic [7:0] CMD_PSIZE_INQ  = 8'h27;
	localparam logic [7:0] CMD_DEV_SEL    = 8'h10;
	localparam logic [7:0] CMD_CLK_SEL    = 8'h11;
	localparam logic [7:0] CMD_RATE_SEL   = 8'h3F;
	localparam logic [7:0] CMD_KEY_ENTER  = 8'h40;
	localparam logic [7:0] CMD_KEY_CHECK  = 8'h60;
	localparam logic [7:0] CMD_STATUS_INQ = 8'h4F;

	localparam logic [7:0] RSP_DEV_INQ    = 8'h30;
	localparam logic [7:0] RSP_CLK_INQ    = 8'h31;
	localparam logic [7:0] RSP_RATIO_INQ  = 8'h32;
	localparam logic [7:0] RSP_FREQ_INQ   = 8'h33;
	localparam logic [7:0] ACK_DEV_SEL    = 8'h36;
	localparam logic [7:0] ACK_CLK_SEL    = 8'h06;
	localparam logic [7:0] ERR_CMD        = 8'h80;
	localparam logic [7:0] ERR_DEV_SEL    = 8'h90;
	localparam logic [7:0] ERR_CLK_SEL    = 8'h91;
	localparam logic [7:0] ECODE_SUM      = 8'h11;
	localparam logic [7:0] ECODE_DEV      = 8'h21;
	localparam logic [7:0] ECODE_MODE     = 8'h22;
	localparam logic [7:0] SUM_ZERO       = 8'h00;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam logic [7:0] DEV_SEL_LEN    = 8'h07;
	localparam logic [7:0] CLK_SEL_LEN    = 8'h04;
	localparam logic [7:0] DEV_SEL_SIZE   = 8'h04;
	localparam logic [7:0] CLK_SEL_SIZE   = 8'h01;
	localparam logic [7:0] CODE_LEN       = 8'h04;
	localparam int         ENTRY_LEN      = 10;
	localparam int         ENTRY_TBL      = 8;
	localparam int         HDR_LEN        = 2;

	// ------------------------------------------------------------
	// supported tables (device and product codes are arbitrary)
	// ------------------------------------------------------------
	localparam int NUM_DEV = 2;
	localparam logic [NUM_DEV*ENTRY_TBL*8-1:0] DEV_TABLE = {
		32'h44563031, 32'h50413031,
		32'h44563032, 32'h50413032};
	localparam int NUM_MODES = 2;
	localparam logic [NUM_MODES*8-1:0] MODE_TABLE = {8'h00, 8'h01};
	localparam int RATIO_LEN = 7;
	localparam logic [RATIO_LEN*8-1:0] RATIO_TABLE = {
		8'h02, 8'h02, 8'h04, 8'h08, 8'h02, 8'h02, 8'hFE};
	localparam int FREQ_LEN = 9;
	localparam logic [FREQ_LEN*8-1:0] FREQ_TABLE = {
		8'h02, 16'h07D0, 16'h2710, 16'h03E8, 16'h1388};

	// ------------------------------------------------------------
	// serial frame timing
	// ------------------------------------------------------------
	localparam int         BAUD_W     = 16;
	localparam logic [3:0] DATA_BITS  = 4'h8;
	localparam logic [3:0] FRAME_BITS = 4'hA;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BISC_PH_INQ,
		BISC_PH_KEY,
		BISC_PH_PROG
	} bisc_phase_type;

	typedef enum logic [2:0] {
		BISC_K_DEV,
		BISC_K_CLK,
		BISC_K_RATIO,
		BISC_K_FREQ,
		BISC_K_SHORT
	} bisc_rsp_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} bisc_byte_type;

	typedef struct packed {
		logic       dev_valid;
		logic       dev_idx;
		logic       mode_valid;
		logic [7:0] mode;
	} bisc_sel_type;

endpackage

// File: verilog/bisc_serial_link.sv
module bisc_serial_link (
	input  wire logic                        clk_i,     // system clock
	input  wire logic                        reset_i,   // async reset, high
	input  wire logic                        rxd_i,     // serial receive pin
	input  wire logic [bisc_pkg::BAUD_W-1:0] baud_div_i, // clocks per bit
	input  wire logic                        tx_go_i,   // send tx_data_i
	input  wire logic [7:0]                  tx_data_i, // byte to send
	output logic                             tx_ready_o, // transmitter idle
	output logic                             txd_o,     // serial transmit pin
	output bisc_pkg::bisc_byte_type          rx_o       // received byte pulse
);

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} bisc_rx_type;

	bisc_rx_type                 rx_st_q, rx_st_d;
	logic [bisc_pkg::BAUD_W-1:0] rx_cnt_q, rx_cnt_d;
	logic [3:0]                  rx_bit_q, rx_bit_d;
	logic [7:0]                  rx_sh_q, rx_sh_d;
	logic                        sync1_q, sync2_q;
	bisc_pkg::bisc_byte_type     rx_d;

	always_comb begin
		rx_st_d  = rx_st_q;
		rx_cnt_d = rx_cnt_q - 1'b1;
		rx_bit_d = rx_bit_q;
		rx_sh_d  = rx_sh_q;
		rx_d     = '{valid: 1'b0, data: rx_sh_q};
		unique case (rx_st_q)
			RX_IDLE: begin
				rx_cnt_d = baud_div_i >> 1;
				if (!sync2_q) begin
					rx_st_d = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_q == '0) begin
					rx_cnt_d = baud_div_i - 1'b1;
					rx_bit_d = '0;
					rx_st_d  = sync2_q ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == '0) begin
					rx_cnt_d = baud_div_i - 1'b1;
					rx_sh_d  = {sync2_q, rx_sh_q[7:1]};
					rx_bit_d = rx_bit_q + 1'b1;
					if (rx_bit_q == bisc_pkg::DATA_BITS - 1'b1) begin
						rx_st_d = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_cnt_q == '0) begin
					rx_d.valid = sync2_q;
					rx_st_d    = RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_q  <= 1'b1;
			sync2_q  <= 1'b1;
			rx_st_q  <= RX_IDLE;
			rx_cnt_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q  <= '0;
			rx_o     <= '0;
		end else begin
			sync1_q  <= rxd_i;
			sync2_q  <= sync1_q;
			rx_st_q  <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q  <= rx_sh_d;
			rx_o     <= rx_d;
		end
	end

	// ------------------------------------------------------------
	// transmitter: start bit, eight data bits lsb first, stop bit
	// ------------------------------------------------------------
	logic [9:0]                  tx_sh_q, tx_sh_d;
	logic [3:0]                  tx_bit_q, tx_bit_d;
	logic [bisc_pkg::BAUD_W-1:0] tx_cnt_q, tx_cnt_d;
	logic                        tx_busy_q, tx_busy_d;
	logic                        txd_d;

	always_comb begin
		tx_sh_d   = tx_sh_q;
		tx_bit_d  = tx_bit_q;
		tx_cnt_d  = tx_cnt_q;
		tx_busy_d = tx_busy_q;
		txd_d     = txd_o;
		if (!tx_busy_q) begin
			if (tx_go_i) begin
				tx_sh_d   = {1'b1, tx_data_i, 1'b0};
				tx_bit_d  = '0;
				tx_cnt_d  = baud_div_i - 1'b1;
				tx_busy_d = 1'b1;
				txd_d     = 1'b0;
			end
		end else if (tx_cnt_q == '0) begin
			tx_cnt_d = baud_div_i - 1'b1;
			tx_bit_d = tx_bit_q + 1'b1;
			tx_sh_d  = {1'b1, tx_sh_q[9:1]};
			if (tx_bit_q == bisc_pkg::FRAME_BITS - 1'b1) begin
				tx_busy_d = 1'b0;
				txd_d     = 1'b1;
			end else begin
				txd_d = tx_sh_q[1];
			end
		end else begin
			tx_cnt_d = tx_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tx_sh_q   <= '1;
			tx_bit_q  <= '0;
			tx_cnt_q  <= '0;
			tx_busy_q <= 1'b0;
			txd_o     <= 1'b1;
		end else begin
			tx_sh_q   <= tx_sh_d;
			tx_bit_q  <= tx_bit_d;
			tx_cnt_q  <= tx_cnt_d;
			tx_busy_q <= tx_busy_d;
			txd_o     <= txd_d;
		end
	end

	assign tx_ready_o = !tx_busy_q;

endmodule

// File: verilog/bisc_cmd_interp.sv
module bisc_cmd_interp (
	input  wire logic                        clk_i,      // 25 MHz system clock
	input  wire logic                        reset_i,    // async reset, high
	input  wire logic                        rxd_i,      // serial receive pin
	input  wire logic [bisc_pkg::BAUD_W-1:0] baud_div_i, // adjusted clocks per bit
	input  bisc_pkg::bisc_phase_type         phase_i,    // current boot phase
	output logic                             txd_o,      // serial transmit pin
	output bisc_pkg::bisc_sel_type           sel_o,      // recorded selections
	output bisc_pkg::bisc_byte_type          fwd_o       // command owned elsewhere
);

	// ------------------------------------------------------------
	// serial link
	// ------------------------------------------------------------
	bisc_pkg::bisc_byte_type rx;
	logic                    tx_ready;
	logic                    tx_go;
	logic [7:0]              tx_data;

	bisc_serial_link u_link (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.rxd_i      (rxd_i),
		.baud_div_i (baud_div_i),
		.tx_go_i    (tx_go),
		.tx_data_i  (tx_data),
		.tx_ready_o (tx_ready),
		.txd_o      (txd_o),
		.rx_o       (rx)
	);

	// ------------------------------------------------------------
	// reply frame contents
	// ------------------------------------------------------------
	function automatic logic [7:0] body_len(input bisc_pkg::bisc_rsp_type k,
	                                        input bisc_pkg::bisc_sel_type s);
		int n;
		n = 0;
		unique case (k)
			bisc_pkg::BISC_K_DEV: begin
				n = s.dev_valid ? 1 : bisc_pkg::NUM_DEV;
				n = 1 + n * bisc_pkg::ENTRY_LEN;
			end
			bisc_pkg::BISC_K_CLK:   n = s.mode_valid ? 1 : bisc_pkg::NUM_MODES;
			bisc_pkg::BISC_K_RATIO: n = bisc_pkg::RATIO_LEN;
			bisc_pkg::BISC_K_FREQ:  n = bisc_pkg::FREQ_LEN;
			bisc_pkg::BISC_K_SHORT: n = 0;
		endcase
		return 8'(n);
	endfunction

	function automatic logic [7:0] frame_byte(input bisc_pkg::bisc_rsp_type k,
	                                          input logic [7:0] i,
	                                          input bisc_pkg::bisc_sel_type s);
		int b, e, d, p;
		logic [7:0] r;
		b = int'(i) - bisc_pkg::HDR_LEN;
		e = 0;
		d = 0;
		p = 0;
		r = 8'h00;
		if (i == 8'h01) begin
			r = body_len(k, s);
		end else begin
			unique case (k)
				bisc_pkg::BISC_K_DEV: begin
					if (i == 8'h00) begin
						r = bisc_pkg::RSP_DEV_INQ;
					end else if (b == 0) begin
						r = s.dev_valid ? 8'h01 : 8'(bisc_pkg::NUM_DEV);
					end else begin
						e = (b - 1) % bisc_pkg::ENTRY_LEN;
						d = (b - 1) / bisc_pkg::ENTRY_LEN + (s.dev_valid ? int'(s.dev_idx) : 0);
						if (e == 0 || e == int'(bisc_pkg::CODE_LEN) + 1) begin
							r = bisc_pkg::CODE_LEN;
						end else begin
							p = d * bisc_pkg::ENTRY_TBL + (e <= int'(bisc_pkg::CODE_LEN) ? e - 1 : e - 2);
							r = bisc_pkg::DEV_TABLE[(bisc_pkg::NUM_DEV * bisc_pkg::ENTRY_TBL - 1 - p) * 8 +: 8];
						end
					end
				end
				bisc_pkg::BISC_K_CLK: begin
					if (i == 8'h00) begin
						r = bisc_pkg::RSP_CLK_INQ;
					end else if (s.mode_valid) begin
						r = s.mode;
					end else begin
						r = bisc_pkg::MODE_TABLE[(bisc_pkg::NUM_MODES - 1 - b) * 8 +: 8];
					end
				end
				bisc_pkg::BISC_K_RATIO: begin
					r = (i == 8'h00) ? bisc_pkg::RSP_RATIO_INQ :
					    bisc_pkg::RATIO_TABLE[(bisc_pkg::RATIO_LEN - 1 - b) * 8 +: 8];
				end
				bisc_pkg::BISC_K_FREQ: begin
					r = (i == 8'h00) ? bisc_pkg::RSP_FREQ_INQ :
					    bisc_pkg::FREQ_TABLE[(bisc_pkg::FREQ_LEN - 1 - b) * 8 +: 8];
				end
				bisc_pkg::BISC_K_SHORT: r = 8'h00;
			endcase
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// command interpreter
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_CMD, ST_ARGS, ST_SEND} bisc_state_type;

	bisc_state_type          st_q, st_d;
	bisc_pkg::bisc_rsp_type  kind_q, kind_d;
	bisc_pkg::bisc_sel_type  sel_d;
	bisc_pkg::bisc_byte_type fwd_d;
	logic [7:0]              cmd_q, cmd_d;
	logic [7:0]              cnt_q, cnt_d;
	logic [7:0]              rsum_q, rsum_d;
	logic [7:0]              size_q, size_d;
	logic [31:0]             code_q, code_d;
	logic [7:0]              idx_q, idx_d;
	logic [7:0]              tsum_q, tsum_d;
	logic [7:0]              s0_q, s0_d;
	logic [7:0]              s1_q, s1_d;
	logic [7:0]              slen_q, slen_d;
	logic [7:0]              last;
	logic [7:0]              fsum;
	logic                    inq;
	logic                    hit;
	logic                    hit_idx;

	always_comb begin
		st_d    = st_q;
		kind_d  = kind_q;
		sel_d   = sel_o;
		fwd_d   = '{valid: 1'b0, data: rx.data};
		cmd_d   = cmd_q;
		cnt_d   = cnt_q;
		rsum_d  = rsum_q;
		size_d  = size_q;
		code_d  = code_q;
		idx_d   = idx_q;
		tsum_d  = tsum_q;
		s0_d    = s0_q;
		s1_d    = s1_q;
		slen_d  = slen_q;
		tx_go   = 1'b0;
		tx_data = 8'h00;
		inq     = (phase_i == bisc_pkg::BISC_PH_INQ);
		fsum    = rsum_q + rx.data;
		hit     = 1'b0;
		hit_idx = 1'b0;
		for (int k = 0; k < bisc_pkg::NUM_DEV; k++) begin
			if (code_q == bisc_pkg::DEV_TABLE[(bisc_pkg::NUM_DEV - k) * bisc_pkg::ENTRY_TBL * 8 - 1 -: 32]) begin
				hit     = 1'b1;
				hit_idx = 1'(k);
			end
		end
		last = (kind_q == bisc_pkg::BISC_K_SHORT) ? slen_q :
		       8'(bisc_pkg::HDR_LEN) + body_len(kind_q, sel_o);
		unique case (st_q)
			ST_CMD: begin
				if (rx.valid) begin
					cmd_d  = rx.data;
					idx_d  = '0;
					tsum_d = '0;
					kind_d = bisc_pkg::BISC_K_SHORT;
					s0_d   = bisc_pkg::ERR_CMD;
					s1_d   = rx.data;
					slen_d = 8'h02;
					st_d   = ST_SEND;
					cnt_d  = 8'h01;
					rsum_d = rx.data;
					case (rx.data)
						bisc_pkg::CMD_DEV_INQ: begin
							if (inq) kind_d = bisc_pkg::BISC_K_DEV;
						end
						bisc_pkg::CMD_CLK_INQ: begin
							if (inq) kind_d = bisc_pkg::BISC_K_CLK;
						end
						bisc_pkg::CMD_RATIO_INQ: begin
							if (inq && sel_o.mode_valid) kind_d = bisc_pkg::BISC_K_RATIO;
						end
						bisc_pkg::CMD_FREQ_INQ: begin
							if (inq && sel_o.mode_valid) kind_d = bisc_pkg::BISC_K_FREQ;
						end
						bisc_pkg::CMD_DEV_SEL: begin
							if (inq) st_d = ST_ARGS;
						end
						bisc_pkg::CMD_CLK_SEL: begin
							if (inq && sel_o.dev_valid) st_d = ST_ARGS;
						end
						bisc_pkg::CMD_UBOOT_INQ, bisc_pkg::CMD_USER_INQ,
						bisc_pkg::CMD_BLOCK_INQ, bisc_pkg::CMD_PSIZE_INQ,
						bisc_pkg::CMD_RATE_SEL: begin
							if (inq && sel_o.mode_valid) begin
								fwd_d.valid = 1'b1;
								st_d        = ST_CMD;
							end
						end
						bisc_pkg::CMD_KEY_ENTER: begin
							if (inq) begin
								fwd_d.valid = 1'b1;
								st_d        = ST_CMD;
							end
						end
						bisc_pkg::CMD_KEY_CHECK: begin
							if (phase_i == bisc_pkg::BISC_PH_KEY) begin
								fwd_d.valid = 1'b1;
								st_d        = ST_CMD;
							end
						end
						bisc_pkg::CMD_STATUS_INQ: begin
							if (phase_i != bisc_pkg::BISC_PH_KEY) begin
								fwd_d.valid = 1'b1;
								st_d        = ST_CMD;
							end
						end
						default: ;
					endcase
				end
			end
			ST_ARGS: begin
				if (rx.valid) begin
					rsum_d = fsum;
					cnt_d  = cnt_q + 1'b1;
					if (cnt_q == 8'h01) begin
						size_d = rx.data;
					end else begin
						code_d = {code_q[23:0], rx.data};
					end
					idx_d  = '0;
					tsum_d = '0;
					slen_d = 8'h02;
					if (cmd_q == bisc_pkg::CMD_DEV_SEL && cnt_q == bisc_pkg::DEV_SEL_LEN - 1'b1) begin
						st_d = ST_SEND;
						s0_d = bisc_pkg::ERR_DEV_SEL;
						if (fsum != bisc_pkg::SUM_ZERO || size_q != bisc_pkg::DEV_SEL_SIZE) begin
							s1_d = bisc_pkg::ECODE_SUM;
						end else if (!hit) begin
							s1_d = bisc_pkg::ECODE_DEV;
						end else begin
							s0_d             = bisc_pkg::ACK_DEV_SEL;
							slen_d           = 8'h01;
							sel_d.dev_valid  = 1'b1;
							sel_d.dev_idx    = hit_idx;
						end
					end
					if (cmd_q == bisc_pkg::CMD_CLK_SEL && cnt_q == bisc_pkg::CLK_SEL_LEN - 1'b1) begin
						st_d = ST_SEND;
						s0_d = bisc_pkg::ERR_CLK_SEL;
						if (fsum != bisc_pkg::SUM_ZERO || size_q != bisc_pkg::CLK_SEL_SIZE) begin
							s1_d = bisc_pkg::ECODE_SUM;
						end else if (!(code_q[7:0] inside {bisc_pkg::MODE_TABLE[15:8],
						                                   bisc_pkg::MODE_TABLE[7:0]})) begin
							s1_d = bisc_pkg::ECODE_MODE;
						end else begin
							s0_d             = bisc_pkg::ACK_CLK_SEL;
							slen_d           = 8'h01;
							sel_d.mode_valid = 1'b1;
							sel_d.mode       = code_q[7:0];
						end
					end
				end
			end
			ST_SEND: begin
				if (tx_ready) begin
					tx_go = 1'b1;
					if (kind_q == bisc_pkg::BISC_K_SHORT) begin
						tx_data = (idx_q == 8'h00) ? s0_q : s1_q;
					end else if (idx_q == last) begin
						tx_data = bisc_pkg::SUM_ZERO - tsum_q;
					end else begin
						tx_data = frame_byte(kind_q, idx_q, sel_o);
					end
					tsum_d = tsum_q + tx_data;
					idx_d  = idx_q + 1'b1;
					if ((kind_q == bisc_pkg::BISC_K_SHORT && idx_q == slen_q - 1'b1) ||
					    (kind_q != bisc_pkg::BISC_K_SHORT && idx_q == last)) begin
						st_d = ST_CMD;
					end
				end
			end
			default: st_d = ST_CMD;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_q   <= ST_CMD;
			kind_q <= bisc_pkg::BISC_K_SHORT;
			sel_o  <= '0;
			fwd_o  <= '0;
			cmd_q  <= '0;
			cnt_q  <= '0;
			rsum_q <= '0;
			size_q <= '0;
			code_q <= '0;
			idx_q  <= '0;
			tsum_q <= '0;
			s0_q   <= '0;
			s1_q   <= '0;
			slen_q <= '0;
		end else begin
			st_q   <= st_d;
			kind_q <= kind_d;
			sel_o  <= sel_d;
			fwd_o  <= fwd_d;
			cmd_q  <= cmd_d;
			cnt_q  <= cnt_d;
			rsum_q <= rsum_d;
			size_q <= size_d;
			code_q <= code_d;
			idx_q  <= idx_d;
			tsum_q <= tsum_d;
			s0_q   <= s0_d;
			s1_q   <= s1_d;
			slen_q <= slen_d;
		end
	end

endmodule

// File: verif/bisc_cmd_interp_chk.sv
module bisc_cmd_interp_chk (
	input  wire logic                        clk_i,      // system clock
	input  wire logic                        reset_i,    // async reset, high
	input  wire logic                        rxd_i,      // serial receive pin
	input  wire logic [bisc_pkg::BAUD_W-1:0] baud_div_i, // clocks per bit
	input  bisc_pkg::bisc_phase_type         phase_i,    // boot phase
	input  wire logic                        txd_o,      // serial transmit pin
	input  bisc_pkg::bisc_sel_type           sel_o,      // recorded selections
	input  bisc_pkg::bisc_byte_type          fwd_o       // forwarded command byte
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	property p_mode_dev;
		sel_o.mode_valid |-> sel_o.dev_valid;
	endproperty
	a_mode_dev: assert property (p_mode_dev) else $error("mode recorded without device");
	property p_dev_kept;
		sel_o.dev_valid |=> sel_o.dev_valid;
	endproperty
	a_dev_kept: assert property (p_dev_kept) else $error("device selection lost");
	property p_mode_ok;
		sel_o.mode_valid |-> sel_o.mode inside {8'h00, 8'h01};
	endproperty
	a_mode_ok: assert property (p_mode_ok) else $error("unsupported mode recorded");
	property p_sel_phase;
		$changed(sel_o) |-> phase_i == bisc_pkg::BISC_PH_INQ;
	endproperty
	a_sel_phase: assert property (p_sel_phase) else $error("selection outside inquiry phase");
	property p_fwd_pulse;
		fwd_o.valid |=> !fwd_o.valid;
	endproperty
	a_fwd_pulse: assert property (p_fwd_pulse) else $error("forward pulse too long");
	property p_fwd_legal;
		fwd_o.valid |-> fwd_o.data inside {8'h24, 8'h25, 8'h26, 8'h27, 8'h3F, 8'h40, 8'h60,
			8'h4F} && (phase_i != bisc_pkg::BISC_PH_KEY || fwd_o.data == 8'h60);
	endproperty
	a_fwd_legal: assert property (p_fwd_legal) else $error("illegal byte forwarded");
	property p_tx_bit;
		$fell(txd_o) |-> (!txd_o) [*4];
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("serial bit too short");
	property p_fwd_quiet;
		fwd_o.valid |-> txd_o [*8];
	endproperty
	a_fwd_quiet: assert property (p_fwd_quiet) else $error("forwarded command answered");

	c_dev: cover property ($rose(sel_o.dev_valid));
	c_mode: cover property ($rose(sel_o.mode_valid));
	c_fwd: cover property (fwd_o.valid);
endmodule

bind bisc_cmd_interp bisc_cmd_interp_chk u_chk (
	.clk_i      (clk_i),
	.reset_i    (reset_i),
	.rxd_i      (rxd_i),
	.baud_div_i (baud_div_i),
	.phase_i    (phase_i),
	.txd_o      (txd_o),
	.sel_o      (sel_o),
	.fwd_o      (fwd_o)
);

// File: verif/bisc_host.sv
module bisc_host (
	input  wire logic                        clk_i,  // system clock
	input  wire logic [bisc_pkg::BAUD_W-1:0] baud_i, // clocks per bit
	input  wire logic                        txd_i,  // device transmit pin
	output logic                             rxd_o   // device receive pin, idle high
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxd_o = 1'b1;
	// one 8N1 byte lsb first; full stop bit so the receiver's late sample still sees it
	task automatic put(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_i);
			rxd_o = f[i];
			repeat (baud_i - 1) @(negedge clk_i);
		end
	endtask
	task automatic get(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (txd_i !== 1'b0 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000)
			return;
		repeat (baud_i / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (baud_i) @(posedge clk_i);
			b[i] = txd_i;
		end
		repeat (baud_i) @(posedge clk_i);
		ok = (txd_i === 1'b1);
	endtask
endmodule

// File: verif/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [7:0] bisc_bq_type[$];
	logic                        clk        = 1'b0;
	logic                        reset      = 1'b1;
	logic                        rxd;
	logic                        txd;
	logic [bisc_pkg::BAUD_W-1:0] baud       = 16'h0008;
	bisc_pkg::bisc_phase_type    phase      = bisc_pkg::BISC_PH_INQ;
	bisc_pkg::bisc_sel_type      sel;
	bisc_pkg::bisc_byte_type     fwd;
	int                          fail_count = 0;
	int                          n_checks   = 0;
	int                          fwd_n      = 0;
	logic [7:0]                  fwd_last   = 8'h00;
	bisc_bq_type                 none;

	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (fwd.valid === 1'b1) begin
			fwd_n <= fwd_n + 1;
			fwd_last <= fwd.data;
		end
	end

	bisc_cmd_interp uut (.clk_i(clk), .reset_i(reset), .rxd_i(rxd), .baud_div_i(baud),
		.phase_i(phase), .txd_o(txd), .sel_o(sel), .fwd_o(fwd));
	bisc_host host (.clk_i(clk), .baud_i(baud), .txd_i(txd), .rxd_o(rxd));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic bisc_bq_type fr(input bisc_bq_type q);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i]) s = s + q[i];
		q.push_back(8'h00 - s);
		return q;
	endfunction
	task automatic cmd(input bisc_bq_type tx, input bisc_bq_type ex);
		logic [7:0] b;
		logic       ok;
		logic       xtra;
		xtra = 1'b0;
		foreach (tx[i]) host.put(tx[i]);
		foreach (ex[i]) begin
			host.get(b, ok);
			chk(b, ex[i]);
			chk({7'h0, ok}, 8'h01);
		end
		repeat (3 * baud) begin
			@(negedge clk);
			xtra = xtra | (txd !== 1'b1);
		end
		chk({7'h0, xtra}, 8'h00);
	endtask
	task automatic fwd_chk(input logic [7:0] b);
		int n0;
		n0 = fwd_n;
		cmd('{b}, none);
		chk(8'(fwd_n - n0), 8'h01);
		chk(fwd_last, b);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_unknown();
		cmd('{8'h55}, '{8'h80, 8'h55});
		cmd('{8'hA7}, '{8'h80, 8'hA7});
	endtask
	task automatic t_early();
		bisc_bq_type l;
		l = '{8'h22, 8'h23, 8'h27, 8'h3F, 8'h11};
		foreach (l[i]) cmd('{l[i]}, '{8'h80, l[i]});
	endtask
	task automatic t_dev();
		bisc_bq_type q;
		cmd('{8'h20}, fr('{8'h30, 8'h15, 8'h02, 8'h04, 8'h44, 8'h56, 8'h30, 8'h31, 8'h04,
			8'h50, 8'h41, 8'h30, 8'h31, 8'h04, 8'h44, 8'h56, 8'h30, 8'h32, 8'h04, 8'h50,
			8'h41, 8'h30, 8'h32}));
		q = fr('{8'h10, 8'h04, 8'h44, 8'h56, 8'h30, 8'h31});
		q[6] = q[6] + 8'h01;
		cmd(q, '{8'h90, 8'h11});
		cmd(fr('{8'h10, 8'h04, 8'h44, 8'h56, 8'h30, 8'h39}), '{8'h90, 8'h21});
		chk({7'h0, sel.dev_valid}, 8'h00);
		cmd(fr('{8'h10, 8'h04, 8'h44, 8'h56, 8'h30, 8'h32}), '{8'h36});
		chk({6'h0, sel.dev_valid, sel.dev_idx}, 8'h03);
		cmd('{8'h20}, fr('{8'h30, 8'h0B, 8'h01, 8'h04, 8'h44, 8'h56, 8'h30, 8'h32, 8'h04,
			8'h50, 8'h41, 8'h30, 8'h32}));
	endtask
	task automatic t_clk();
		bisc_bq_type q;
		cmd('{8'h21}, fr('{8'h31, 8'h02, 8'h00, 8'h01}));
		cmd(fr('{8'h11, 8'h01, 8'h05}), '{8'h91, 8'h22});
		q = fr('{8'h11, 8'h01, 8'h01});
		q[3] = ~q[3];
		cmd(q, '{8'h91, 8'h11});
		cmd(fr('{8'h11, 8'h01, 8'h01}), '{8'h06});
		chk({sel.mode_valid, sel.mode[6:0]}, 8'h81);
		cmd('{8'h21}, fr('{8'h31, 8'h01, 8'h01}));
	endtask
	task automatic t_info();
		cmd('{8'h22}, fr('{8'h32, 8'h07, 8'h02, 8'h02, 8'h04, 8'h08, 8'h02, 8'h02, 8'hFE}));
		cmd('{8'h23}, fr('{8'h33, 8'h09, 8'h02, 8'h07, 8'hD0, 8'h27, 8'h10, 8'h03, 8'hE8,
			8'h13, 8'h88}));
		fwd_chk(8'h24);
	endtask
	task automatic t_phase();
		@(negedge clk);
		phase = bisc_pkg::BISC_PH_KEY;
		cmd('{8'h20}, '{8'h80, 8'h20});
		fwd_chk(8'h60);
		@(negedge clk);
		phase = bisc_pkg::BISC_PH_PROG;
		fwd_chk(8'h4F);
		cmd('{8'h60}, '{8'h80, 8'h60});
		@(negedge clk);
		phase = bisc_pkg::BISC_PH_INQ;
		baud = 16'h0006;
		cmd('{8'h21}, fr('{8'h31, 8'h01, 8'h01}));
	endtask

	task automatic finish_test();
		$display("checks=%0d fails=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#4000000;
		fail_count++;
		finish_test();
	end

	// selections go device first, then clock mode, ratio and frequency inquiries after
	initial begin
		repeat (8) @(negedge clk);
		reset = 1'b0;
		chk({7'h0, txd}, 8'h01);
		chk({6'h0, sel.dev_valid, sel.mode_valid}, 8'h00);
		t_unknown();
		t_early();
		t_dev();
		t_clk();
		t_info();
		t_phase();
		finish_test();
	end
endmodule
